// ==== tmic_pkg.sv ====
// Purpose: shared constants and types for the time interval counter
// Assumes: 8-bit special function register bus from the core, 40 MHz CLK
// Notes: crystal is a 32.768 kHz input sampled on CLK
package tmic_pkg;

    // register addresses
    localparam logic [7:0] ADDR_CTRL = 8'ha1;
    localparam logic [7:0] ADDR_FRAC = 8'ha2;
    localparam logic [7:0] ADDR_SEC = 8'ha3;
    localparam logic [7:0] ADDR_MIN = 8'ha4;
    localparam logic [7:0] ADDR_HOUR = 8'ha5;
    localparam logic [7:0] ADDR_INTERVAL_COMPARE_VALUE = 8'ha6;

    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] TIME_RESET = 8'h00;
    localparam logic [7:0] INTERVAL_COMPARE_VALUE_RESET = 8'h00;

    // control register field positions
    localparam int CTRL_TBSEL_HI = 5;
    localparam int CTRL_TBSEL_LO = 4;
    localparam int CTRL_SINGLE = 3;
    localparam int CTRL_FLAG = 2;
    localparam int CTRL_IEN = 1;
    localparam int CTRL_TIME_CLOCK_ENABLE = 0;

    // timebase select encodings
    typedef enum logic [1:0] {
        TMIC_TB_FRAC = 2'h0,
        TMIC_TB_SEC = 2'h1,
        TMIC_TB_MIN = 2'h2,
        TMIC_TB_HOUR = 2'h3
    } tmic_tbsel_t;

    // time register chain: fraction, seconds, minutes, hours
    localparam int NUM_TIME = 4;
    localparam logic [7:0] FRAC_MAX = 8'h7f;
    localparam logic [7:0] SEC_MAX = 8'h3b;
    localparam logic [7:0] MIN_MAX = 8'h3b;
    localparam logic [7:0] HOUR_MAX = 8'h17;
    localparam logic [4*8-1:0] TIME_MAX = {HOUR_MAX, MIN_MAX, SEC_MAX, FRAC_MAX};

    // crystal timing
    localparam int XTAL_HZ = 32768;
    localparam int FRAC_PER_SEC = 128;
    localparam int XTAL_PER_FRAC = XTAL_HZ / FRAC_PER_SEC;
    localparam logic [7:0] PRE_MAX = 8'(XTAL_PER_FRAC - 1);

    // wake vector address
    localparam logic [15:0] WAKE_VECTOR = 16'h0053;

    // core register access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tmic_sfr_req_t;

endpackage

// ==== tmic_modcnt.sv ====
// Purpose: one modulo time register with load, clear and wrap output
// Assumes: inc, clr and load are single-cycle strobes on clk
// Notes: wrap is combinational and marks the carry into the next register
`timescale 1ns/100ps
module tmic_modcnt (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic inc,
    input wire logic load,
    input wire logic [7:0] load_val,
    input wire logic [7:0] max_val,
    output logic [7:0] count,
    output logic wrap
);
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic at_max;

    // rollover at the top of the range
    assign at_max = (count_q == max_val);
    assign wrap = inc && at_max;
    assign count_d = clr ? 8'h00 :
                     load ? load_val :
                     wrap ? 8'h00 :
                     inc ? count_q + 8'h01 : count_q;
    assign count = count_q;

    // count register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= tmic_pkg::TIME_RESET;
        end else begin
            count_q <= count_d;
        end
    end
endmodule // tmic_modcnt

// ==== tmic_top.sv ====
// Purpose: time interval counter with real-time clock registers
// Assumes: register access over the core's special function register bus
// Notes: the crystal is sampled on CLK; counting needs CLK running as well as crystal edges
`timescale 1ns/100ps
module tmic_top (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic XTAL_CLK,
    input wire tmic_pkg::tmic_sfr_req_t SFR_REQ,
    output logic [7:0] SFR_RDATA,
    input wire logic IRQ_ENABLE,
    input wire logic POWER_DOWN,
    output logic IRQ,
    output logic WAKE,
    output logic [15:0] WAKE_ADDR
);
    // crystal synchroniser
    logic [2:0] xs_q;
    logic xlvl_q;
    logic xtal_rise;

    // control fields
    logic [1:0] tbsel_q;
    logic single_q;
    logic flag_q;
    logic ien_q;
    logic time_clock_enable_q;
    logic [7:0] interval_compare_value_q;
    logic [7:0] icnt_q;
    logic [7:0] icnt_d;
    logic [7:0] pre_q;
    logic [7:0] rdata_q;
    logic irq_q;
    logic wake_q;

    // decode
    logic wr_ctrl;
    logic wr_interval_compare_value;
    logic time_clock_enable_fall;
    logic pre_wrap;
    logic [3:0] time_inc;
    logic [3:0] time_wrap;
    logic [3:0] time_load;
    logic [4*8-1:0] time_cnt;
    logic tb_tick;
    logic icnt_next_match;
    logic timeout;
    logic flag_set;
    logic [7:0] ctrl_rd;
    logic [7:0] rd_mux;

    // next values of the software-written control bits
    logic single_stop;
    logic flag_d;
    logic ien_d;

    // register write decode
    assign wr_ctrl = SFR_REQ.wr && (SFR_REQ.addr == tmic_pkg::ADDR_CTRL);
    assign wr_interval_compare_value = SFR_REQ.wr && (SFR_REQ.addr == tmic_pkg::ADDR_INTERVAL_COMPARE_VALUE);
    assign time_clock_enable_fall = wr_ctrl && time_clock_enable_q && !SFR_REQ.wdata[tmic_pkg::CTRL_TIME_CLOCK_ENABLE];

    // three-stage sample of the crystal, level accepted when stages 2 and 3 agree
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            xs_q <= 3'h0;
            xlvl_q <= 1'b0;
        end else begin
            xs_q <= {xs_q[1:0], XTAL_CLK};
            if (xs_q[2] == xs_q[1]) begin
                xlvl_q <= xs_q[2];
            end
        end
    end

    // one pulse per crystal rising edge
    assign xtal_rise = (xs_q[2] == xs_q[1]) && xs_q[2] && !xlvl_q;

    // crystal prescaler down to 1/128 s
    assign pre_wrap = time_clock_enable_q && xtal_rise && (pre_q == tmic_pkg::PRE_MAX);
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            pre_q <= 8'h00;
        end else if (!time_clock_enable_q) begin
            pre_q <= 8'h00;
        end else if (xtal_rise) begin
            pre_q <= pre_wrap ? 8'h00 : pre_q + 8'h01;
        end
    end

    // chain of time registers, each carry stepping the next
    genvar gi;
    generate
        for (gi = 0; gi < tmic_pkg::NUM_TIME; gi++) begin : g_time
            if (gi == 0) begin : g_first
                assign time_inc[gi] = pre_wrap;
            end else begin : g_next
                assign time_inc[gi] = time_wrap[gi-1];
            end
            // writes only while the time clock is stopped
            assign time_load[gi] = SFR_REQ.wr && !time_clock_enable_q &&
                (SFR_REQ.addr == tmic_pkg::ADDR_FRAC + 8'(gi));
            tmic_modcnt u_cnt (
                .clk(CLK),
                .rst_n(RESETN),
                .clr(time_clock_enable_fall),
                .inc(time_inc[gi]),
                .load(time_load[gi]),
                .load_val(SFR_REQ.wdata),
                .max_val(tmic_pkg::TIME_MAX[gi*8 +: 8]),
                .count(time_cnt[gi*8 +: 8]),
                .wrap(time_wrap[gi])
            );
        end
    endgenerate

    // timebase selection for the interval counter
    assign tb_tick = (tbsel_q == tmic_pkg::TMIC_TB_FRAC) ? time_inc[0] :
                     (tbsel_q == tmic_pkg::TMIC_TB_SEC) ? time_wrap[0] :
                     (tbsel_q == tmic_pkg::TMIC_TB_MIN) ? time_wrap[1] :
                     time_wrap[2];

    // interval counter step, match and reload
    assign icnt_next_match = (icnt_q + 8'h01) == interval_compare_value_q;
    assign timeout = ien_q && tb_tick && icnt_next_match;
    assign flag_set = timeout;
    assign icnt_d = !ien_q ? 8'h00 :
                    timeout ? 8'h00 :
                    tb_tick ? icnt_q + 8'h01 : icnt_q;

    // flag and count enable next values; hardware set and single-shot stop win
    assign single_stop = timeout && single_q;
    assign flag_d = flag_set |
                    (wr_ctrl ? SFR_REQ.wdata[tmic_pkg::CTRL_FLAG] : flag_q);
    assign ien_d = single_stop ? 1'b0 :
                   wr_ctrl ? SFR_REQ.wdata[tmic_pkg::CTRL_IEN] :
                   ien_q;

    // interval counter register
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            icnt_q <= 8'h00;
        end else begin
            icnt_q <= icnt_d;
        end
    end

    // control register; hardware set of the flag beats a software clear
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            tbsel_q <= tmic_pkg::CTRL_RESET[tmic_pkg::CTRL_TBSEL_HI:tmic_pkg::CTRL_TBSEL_LO];
            single_q <= tmic_pkg::CTRL_RESET[tmic_pkg::CTRL_SINGLE];
            flag_q <= tmic_pkg::CTRL_RESET[tmic_pkg::CTRL_FLAG];
            ien_q <= tmic_pkg::CTRL_RESET[tmic_pkg::CTRL_IEN];
            time_clock_enable_q <= tmic_pkg::CTRL_RESET[tmic_pkg::CTRL_TIME_CLOCK_ENABLE];
        end else begin
            if (wr_ctrl) begin
                tbsel_q <= SFR_REQ.wdata[tmic_pkg::CTRL_TBSEL_HI:tmic_pkg::CTRL_TBSEL_LO];
                single_q <= SFR_REQ.wdata[tmic_pkg::CTRL_SINGLE];
                time_clock_enable_q <= SFR_REQ.wdata[tmic_pkg::CTRL_TIME_CLOCK_ENABLE];
            end
            flag_q <= flag_d;
            ien_q <= ien_d;
        end
    end

    // compare value register
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            interval_compare_value_q <= tmic_pkg::INTERVAL_COMPARE_VALUE_RESET;
        end else if (wr_interval_compare_value) begin
            interval_compare_value_q <= SFR_REQ.wdata;
        end
    end

    // read path, reserved bits read zero
    assign ctrl_rd = {2'h0, tbsel_q, single_q, flag_q, ien_q, time_clock_enable_q};
    assign rd_mux = (SFR_REQ.addr == tmic_pkg::ADDR_CTRL) ? ctrl_rd :
                    (SFR_REQ.addr == tmic_pkg::ADDR_FRAC) ? time_cnt[7:0] :
                    (SFR_REQ.addr == tmic_pkg::ADDR_SEC) ? time_cnt[15:8] :
                    (SFR_REQ.addr == tmic_pkg::ADDR_MIN) ? time_cnt[23:16] :
                    (SFR_REQ.addr == tmic_pkg::ADDR_HOUR) ? time_cnt[31:24] :
                    (SFR_REQ.addr == tmic_pkg::ADDR_INTERVAL_COMPARE_VALUE) ? interval_compare_value_q : 8'h00;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rdata_q <= 8'h00;
        end else if (SFR_REQ.rd) begin
            rdata_q <= rd_mux;
        end
    end

    // interrupt request and power-down wake
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            irq_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            irq_q <= flag_q && IRQ_ENABLE;
            wake_q <= flag_q && IRQ_ENABLE && POWER_DOWN;
        end
    end

    // outputs straight from flip-flops, except the constant wake address
    assign SFR_RDATA = rdata_q;
    assign IRQ = irq_q;
    assign WAKE = wake_q;
    assign WAKE_ADDR = tmic_pkg::WAKE_VECTOR;
endmodule // tmic_top

// ==== tmic_properties.sv ====
// Purpose: port-level checks for the time interval counter
// Assumes: one CLK domain, RESETN async active low
// Notes: bound to tmic_top at the foot of this file
`timescale 1ns/100ps
module tmic_properties (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic XTAL_CLK,
    input wire tmic_pkg::tmic_sfr_req_t SFR_REQ,
    input wire logic [7:0] SFR_RDATA,
    input wire logic IRQ_ENABLE,
    input wire logic POWER_DOWN,
    input wire logic IRQ,
    input wire logic WAKE,
    input wire logic [15:0] WAKE_ADDR
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // address of a read, zero when idle
    wire logic [7:0] ra = SFR_REQ.rd ? SFR_REQ.addr : 8'h00;
    wire logic rd_unmapped = SFR_REQ.rd && !(ra inside {[8'ha1:8'ha6]});
    chk_wake_vector: assert property (WAKE_ADDR == 16'h0053)
        else $error("wake address wrong");
    chk_wake_cause: assert property (WAKE |-> $past(POWER_DOWN) && $past(IRQ_ENABLE))
        else $error("wake without cause");
    chk_wake_irq: assert property (WAKE |-> IRQ)
        else $error("wake without irq");
    chk_irq_enable: assert property (IRQ |-> $past(IRQ_ENABLE))
        else $error("irq while disabled");
    chk_irq_sticky: assert property (IRQ && IRQ_ENABLE && !$past(SFR_REQ.wr) |=> IRQ)
        else $error("flag dropped by itself");
    chk_rdata_hold: assert property (!$past(SFR_REQ.rd) |-> $stable(SFR_RDATA))
        else $error("read data moved");
    chk_unmapped_zero: assert property (rd_unmapped |=> SFR_RDATA == 8'h00)
        else $error("unmapped read not zero");
    chk_ctrl_upper: assert property (ra == 8'ha1 |=> SFR_RDATA[7:6] == 2'h0)
        else $error("control upper bits set");
    chk_frac_range: assert property (ra == 8'ha2 |=> SFR_RDATA <= 8'h7f)
        else $error("fraction out of range");
    chk_hour_range: assert property (ra == 8'ha5 |=> SFR_RDATA <= 8'h17)
        else $error("hour out of range");
endmodule // tmic_properties

bind tmic_top tmic_properties u_props (.CLK(CLK), .RESETN(RESETN), .XTAL_CLK(XTAL_CLK),
    .SFR_REQ(SFR_REQ), .SFR_RDATA(SFR_RDATA), .IRQ_ENABLE(IRQ_ENABLE),
    .POWER_DOWN(POWER_DOWN), .IRQ(IRQ), .WAKE(WAKE), .WAKE_ADDR(WAKE_ADDR));

// ==== tmic_core_model.sv ====
// Purpose: core model issuing special function register accesses
// Assumes: one-cycle wr/rd pulses, read data one cycle after the rd edge
// Notes: released address and data lines are inverted, not held
`timescale 1ns/100ps
module tmic_core_model (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output tmic_pkg::tmic_sfr_req_t req
);
    initial req = '0;
    // one write pulse launched just after an edge
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        #1 req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    // one read pulse, data taken once the taking edge has landed
    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        #1 d = rdata;
        req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
    endtask
endmodule // tmic_core_model

// ==== tb_top.sv ====
// Purpose: self-checking bench for the time interval counter
// Assumes: crystal sped up to 8 CLK per period
// Notes: random preloads from a fixed seed
`timescale 1ns/100ps
module tb_top;
    logic clk, resetn, xtal, irq_en, pd, irq, wake;
    logic [7:0] rdata, v;
    logic [7:0] w[4];
    logic [15:0] wake_addr;
    tmic_pkg::tmic_sfr_req_t req;
    int n_fail, checks, seed, n;
    tmic_top dut (.CLK(clk), .RESETN(resetn), .XTAL_CLK(xtal), .SFR_REQ(req), .SFR_RDATA(rdata),
        .IRQ_ENABLE(irq_en), .POWER_DOWN(pd), .IRQ(irq), .WAKE(wake), .WAKE_ADDR(wake_addr));
    tmic_core_model core (.clk(clk), .rdata(rdata), .req(req));
    // core clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // crystal, free running and off phase
    initial begin
        xtal = 1'b0;
        #7;
        forever #100 xtal = ~xtal;
    end
    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // top value of each time register
    function automatic logic [7:0] tmax(int i);
        return (i == 0) ? 8'h7f : (i == 3) ? 8'h17 : 8'h3b;
    endfunction
    // wait for the interrupt request, bounded
    task automatic wait_irq;
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    // preload so that one fraction step overflows the register below k
    function automatic logic [7:0] pre(int i, int k);
        return (i < k || i == 3) ? tmax(i) : 8'h00;
    endfunction
    function automatic logic [7:0] after(int i, int k);
        if (i < k)
            return 8'h00;
        if (i == k)
            return (i == 3) ? 8'h00 : 8'h01;
        return (i == 3) ? 8'h17 : 8'h00;
    endfunction
    // main sequence
    initial begin
        seed = 45;
        n_fail = 0;
        checks = 0;
        resetn = 1'b0;
        irq_en = 1'b0;
        pd = 1'b0;
        repeat (20) @(posedge clk);
        #1 resetn = 1'b1;
        irq_en = 1'b1;
        for (int a = 8'ha0; a <= 8'ha7; a++) begin
            core.sfr_rd(8'(a), v);
            check(v, 8'h00);
        end
        core.sfr_wr(8'ha7, 8'($random(seed)));
        core.sfr_rd(8'ha7, v);
        check(v, 8'h00);
        check(wake_addr[7:0], 8'h53);
        check(wake_addr[15:8], 8'h00);
        for (int i = 0; i < 4; i++) begin
            w[i] = 8'({$random(seed)} % (int'(tmax(i)) + 1));
            core.sfr_wr(8'ha2 + 8'(i), w[i]);
        end
        for (int i = 0; i < 4; i++) begin
            core.sfr_rd(8'ha2 + 8'(i), v);
            check(v, w[i]);
        end
        core.sfr_wr(8'ha1, 8'h01);
        core.sfr_wr(8'ha3, w[1] ^ 8'h01);
        core.sfr_rd(8'ha3, v);
        check(v, w[1]);
        core.sfr_wr(8'ha1, 8'h00);
        core.sfr_rd(8'ha5, v);
        check(v, 8'h00);
        // one timeout per timebase, odd ones in single mode
        for (int k = 0; k < 4; k++) begin
            pd = (k == 2);
            for (int i = 0; i < 4; i++)
                core.sfr_wr(8'ha2 + 8'(i), pre(i, k));
            core.sfr_wr(8'ha6, 8'h01);
            core.sfr_wr(8'ha1, 8'((k << 4) | ((k & 1) << 3) | 3));
            wait_irq();
            check(8'(irq), 8'h01);
            check(8'(wake), 8'(k == 2));
            core.sfr_rd(8'ha1, v);
            check(v, 8'((k << 4) | ((k & 1) << 3) | ((k & 1) ? 5 : 7)));
            for (int i = 0; i < 4; i++) begin
                core.sfr_rd(8'ha2 + 8'(i), v);
                check(v, after(i, k));
            end
            // interrupt enable low masks the standing flag
            irq_en = 1'b0;
            repeat (2) @(posedge clk);
            #1 check(8'(irq), 8'h00);
            irq_en = 1'b1;
            // continuous mode: clear the flag only, counter reloads and times out again
            if (k == 0) begin
                core.sfr_wr(8'ha1, 8'h03);
                repeat (2) @(posedge clk);
                #1 check(8'(irq), 8'h00);
                wait_irq();
                check(8'(irq), 8'h01);
                core.sfr_rd(8'ha2, v);
                check(v, 8'h02);
            end
            core.sfr_wr(8'ha1, 8'h00);
            repeat (3) @(posedge clk);
            #1 check(8'(irq), 8'h00);
        end
        print_verdict();
    end
    // watchdog against a hung wait
    initial begin
        #1000000;
        n_fail++;
        print_verdict();
    end
endmodule // tb_top
